// ---- hdl/ddl_pkg.sv ----
/*
  Constants for the dual converter serial load logic: word layout,
  preset codes and the depth of the load-word buffer.
  Assumes nothing of its surroundings.
*/
package ddl_pkg;
  localparam int WORD_W = 16;
  localparam int CODE_W = 12;
  localparam int BIT_MODE = 15;
  localparam int BIT_SEL_B = 14;
  localparam int BIT_SEL_A = 13;
  localparam int BIT_UNUSED = 12;
  localparam int CODE_MSB = 11;
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [11:0] CODE_HALF = 12'h800;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_W = 14;
  localparam int FIFO_AW = 2;
endpackage

// ---- hdl/ddl_fifo.sv ----
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
module ddl_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- hdl/ddl_top.sv ----
/*
  Serial input and load logic of a dual 12-bit converter.
  Link side (shift register, serial_out) runs on the serial clock;
  channel registers run on clk. Strobes and presets are pins and
  are synchronised into clk before use. The load word is held still
  by the host while a synchronised strobe edge samples it, and the
  sampled word is buffered by a FIFO.
*/
// Function
// - serial clock rising edge with select low shifts serial_in in
// - select high freezes shift register; select never affects strobes
// - word msb first: mode, sel B, sel A, unused, 12 code bits
// - serial_out always driven with the outgoing shift register bit
// - strobe falling edge copies 12 code bits to targeted channels
// - hardware mode, both strobes falling load both channels
// - hardware mode, single strobe loads its own channel only
// - decode mode, B high A low loads channel B only
// - decode mode, both bits load both, A only loads A, none loads none
// - decode mode, either strobe falling triggers the decoded load
// - reset low with preset level low clears channels to 000
// - reset low with preset level high presets channels to 800
// - serial_out shows the bit that entered 16 edges earlier
// - shift register is 16 bits, loads only while select low
`timescale 1ns/1ns
module ddl_top
  import ddl_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic chip_select_n,
  output logic serial_out,
  input wire logic load_strobe_first_n,
  input wire logic load_strobe_second_n,
  input wire logic preset_n,
  input wire logic preset_half,
  output logic [11:0] first_channel_register,
  output logic [11:0] second_channel_register
);
  // ------------------------------------------------------------
  // serial clock domain: shift register
  // ------------------------------------------------------------
  logic [WORD_W-1:0] shift_r;

  // no reset by design: contents survive preset
  always_ff @(posedge serial_clk) begin
    if (!chip_select_n) begin
      shift_r <= {shift_r[WORD_W-2:0], serial_in};
    end
    // select high: hold
  end

  // outgoing bit, 16 edges late; never tri-stated
  assign serial_out = shift_r[WORD_W-1];

  // ------------------------------------------------------------
  // pin synchronisers into clk
  // ------------------------------------------------------------
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;
  logic pre_s1_r;
  logic pre_s2_r;
  logic half_s1_r;
  logic half_s2_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= 2'h3;
      s2_r <= 2'h3;
      s3_r <= 2'h3;
    end else begin
      s1_r <= {load_strobe_second_n, load_strobe_first_n};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // preset pin: async assert, sync release; level pin synchronised
  always_ff @(posedge clk or negedge preset_n) begin
    if (!preset_n) begin
      pre_s1_r <= 1'b0;
      pre_s2_r <= 1'b0;
    end else begin
      pre_s1_r <= 1'b1;
      pre_s2_r <= pre_s1_r;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      half_s1_r <= 1'b0;
      half_s2_r <= 1'b0;
    end else begin
      half_s1_r <= preset_half;
      half_s2_r <= half_s1_r;
    end
  end

  // ------------------------------------------------------------
  // strobe edge detection and decode
  // ------------------------------------------------------------
  // strobes are independent of select
  wire fall_a = s3_r[0] && !s2_r[0];
  wire fall_b = s3_r[1] && !s2_r[1];
  // word is stable: host keeps strobes high while shifting
  wire [WORD_W-1:0] word = shift_r;
  wire mode_sw = word[BIT_MODE];
  wire sel_b = word[BIT_SEL_B];
  wire sel_a = word[BIT_SEL_A];
  wire any_fall = fall_a || fall_b;
  wire hit_a = mode_sw ? (any_fall && sel_a) : fall_a;
  wire hit_b = mode_sw ? (any_fall && sel_b) : fall_b;
  // strobes ignored while preset is held
  wire load_req = pre_s2_r && (hit_a || hit_b);

  // ------------------------------------------------------------
  // load word buffer
  // ------------------------------------------------------------
  logic [FIFO_W-1:0] fifo_out;
  logic fifo_valid;
  logic fifo_in_ready;

  // the word is sampled from the serial domain at each strobe fall that loads a channel,
  // whatever select is; a strobe lost to a full buffer is
  // dropped rather than corrupting a channel
  ddl_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_data({hit_b, hit_a, word[CODE_MSB:0]}),
    .in_valid(load_req && fifo_in_ready),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(pre_s2_r)
  );

  // ------------------------------------------------------------
  // channel registers
  // ------------------------------------------------------------
  wire [11:0] preset_code = half_s2_r ? CODE_HALF : CODE_ZERO;
  wire take = fifo_valid && pre_s2_r;
  logic [11:0] first_r;
  logic [11:0] second_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first_r <= CODE_ZERO;
      second_r <= CODE_ZERO;
    end else if (!pre_s2_r) begin
      first_r <= preset_code;
      second_r <= preset_code;
    end else if (take) begin
      if (fifo_out[CODE_W]) begin
        first_r <= fifo_out[CODE_W-1:0];
      end
      if (fifo_out[CODE_W+1]) begin
        second_r <= fifo_out[CODE_W-1:0];
      end
    end
  end

  assign first_channel_register = first_r;
  assign second_channel_register = second_r;
endmodule

// ---- sim/ddl_host.sv ----
/*
  Host model: shifts one serial frame per call.
  Assumes the bench holds both strobes high meanwhile.
*/
`timescale 1ns/1ns
module ddl_host (
  output logic serial_clk,
  output logic serial_in,
  output logic chip_select_n
);
  initial {serial_clk, serial_in, chip_select_n} = 3'h1;
  // clock stands still between frames, data inverted once released
  task automatic send(input logic [15:0] word, input logic sel_n);
    #3 chip_select_n = sel_n;
    for (int i = 15; i >= 0; i--) begin
      serial_in = word[i];
      #40 serial_clk = 1'b1;
      #40 serial_clk = 1'b0;
    end
    chip_select_n = 1'b1;
    serial_in = ~serial_in;
  endtask
endmodule

// ---- sim/ddl_top_chk.sv ----
/*
  Port checker for ddl_top.
  Assumes the bind below.
*/
`timescale 1ns/1ns
module ddl_top_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic chip_select_n,
  input wire logic serial_out,
  input wire logic load_strobe_first_n,
  input wire logic load_strobe_second_n,
  input wire logic preset_n,
  input wire logic preset_half,
  input wire logic [11:0] first_channel_register,
  input wire logic [11:0] second_channel_register
);
  logic [4:0] run_r;
  wire logic rn = !arst_n;
  wire logic idle = load_strobe_first_n & load_strobe_second_n & preset_n;
  wire logic [23:0] regs = {first_channel_register, second_channel_register};
  // ----
  // selected edges in a row, saturating at 16
  // ----
  always_ff @(posedge serial_clk or negedge arst_n) begin
    if (!arst_n) run_r <= 5'h00;
    else if (chip_select_n) run_r <= 5'h00;
    else if (!run_r[4]) run_r <= run_r + 5'h01;
  end
  a_reset_clear: assert property (@(posedge clk)
    rn [*2] |-> regs == 24'h000000) else $error("reset value");
  a_preset_zero: assert property (@(posedge clk) disable iff (rn)
    (!preset_n & !preset_half) [*4] |-> regs == 24'h000000) else $error("zero");
  a_preset_half: assert property (@(posedge clk) disable iff (rn)
    (!preset_n & preset_half) [*4] |-> regs == 24'h800800) else $error("half");
  a_preset_hold: assert property (@(posedge clk) disable iff (rn)
    !preset_n [*4] |=> $stable(regs)) else $error("load in preset");
  a_idle_hold: assert property (@(posedge clk) disable iff (rn)
    idle [*8] |=> $stable(regs)) else $error("load without strobe");
  a_change_cause: assert property (@(posedge clk) disable iff (rn)
    $changed(regs) |-> !(idle & $past(idle, 2) & $past(idle, 4)
    & $past(idle, 6))) else $error("change without cause");
  a_freeze_shift: assert property (@(posedge serial_clk)
    disable iff (rn) chip_select_n |=> $stable(serial_out)) else $error("shift");
  a_echo_delay: assert property (@(posedge serial_clk)
    disable iff (rn) run_r[4] |-> serial_out == $past(serial_in, 16))
    else $error("echo");
  c_half: cover property (@(posedge clk) regs == 24'h800800);
  c_echo: cover property (@(posedge serial_clk) run_r[4]);
  c_load: cover property (@(posedge clk) $fell(load_strobe_second_n));
endmodule
bind ddl_top ddl_top_chk ddl_top_chk_i (.*);

// ---- sim/test_ddl_top.sv ----
/*
  Bench for ddl_top: frames from ddl_host, strobes and presets here.
  Assumes the checker is bound to ddl_top.
*/
`timescale 1ns/1ns
module test_ddl_top
  import ddl_pkg::*;
();
  logic clk = 1'b0, arst_n = 1'b0, preset_n = 1'b1, preset_half = 1'b0;
  logic load_strobe_first_n = 1'b1, load_strobe_second_n = 1'b1, msb;
  wire logic serial_clk, serial_in, chip_select_n, serial_out;
  wire logic [11:0] first_channel_register, second_channel_register;
  int num_errors = 0, checks_done = 0, cyc = 0;
  // word, select high, strobe a, strobe b, expected a and b
  localparam logic [42:0] TBL [9] = '{{16'h0123, 3'h3, 24'h123123},
    {16'h7456, 3'h2, 24'h456123}, {16'h0789, 3'h1, 24'h456789},
    {16'h0AAA, 3'h0, 24'h456789}, {16'hFFFF, 3'h6, 24'hAAA789},
    {16'hC111, 3'h2, 24'hAAA111}, {16'hA222, 3'h1, 24'h222111},
    {16'hE333, 3'h3, 24'h333333}, {16'h8444, 3'h3, 24'h333333}};
  always #5 clk = ~clk;
  ddl_host ddl_host_i (
    .serial_clk(serial_clk),
    .serial_in(serial_in),
    .chip_select_n(chip_select_n)
  );
  ddl_top ddl_top_i (
    .clk(clk),
    .arst_n(arst_n),
    .serial_clk(serial_clk),
    .serial_in(serial_in),
    .chip_select_n(chip_select_n),
    .serial_out(serial_out),
    .load_strobe_first_n(load_strobe_first_n),
    .load_strobe_second_n(load_strobe_second_n),
    .preset_n(preset_n),
    .preset_half(preset_half),
    .first_channel_register(first_channel_register),
    .second_channel_register(second_channel_register)
  );
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----
  // strobe pulse of three cycles, then room for the load to land
  // ----
  task automatic load(input logic a, input logic b);
    @(negedge clk);
    {load_strobe_first_n, load_strobe_second_n} = {~a, ~b};
    repeat (3) @(negedge clk);
    {load_strobe_first_n, load_strobe_second_n} = 2'h3;
    repeat (8) @(negedge clk);
  endtask
  task automatic preset(input logic half);
    @(negedge clk);
    {preset_n, preset_half} = {1'b0, half};
    repeat (6) @(negedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    chk(first_channel_register, CODE_ZERO);
    arst_n = 1'b1;
    preset(1'b1);
    chk(second_channel_register, CODE_HALF);
    ddl_host_i.send(16'h0555, 1'b0);
    load(1'b1, 1'b1);
    preset_n = 1'b1;
    repeat (6) @(negedge clk);
    chk(first_channel_register, CODE_HALF);
    preset(1'b0);
    chk(second_channel_register, CODE_ZERO);
    preset_n = 1'b1;
    foreach (TBL[i]) begin
      ddl_host_i.send(TBL[i][42:27], TBL[i][26]);
      if (!TBL[i][26]) msb = TBL[i][42];
      chk({11'h000, serial_out}, {11'h000, msb});
      load(TBL[i][25], TBL[i][24]);
      chk(first_channel_register, TBL[i][23:12]);
      chk(second_channel_register, TBL[i][11:0]);
    end
    results();
  end
endmodule
